// ===== bench/ppla_host_model.sv
/*
 * Far-side model: host bus address/data phases and external pin levels.
 * Assumes the bench pulses go_in for one cycle per host bus cycle.
 */
`timescale 1ns/1ps

module ppla_host_model
    import ppla_pkg::*;
#(
    parameter logic [31:0] EXT_LEVEL = 32'h9669_a55a
)
(
    input wire logic clk_sys_in,
    input wire logic go_in,
    input wire logic [15:0] addr_in,
    input wire logic [31:0] pin_drive_in,
    input wire logic [31:0] pin_oe_n_in,
    output logic [15:0] host_ad_out,
    output logic host_ale_out,
    output logic [31:0] pin_level_out
);
    // ======================================================
    // Host bus: address phase with strobe, then data phase
    initial begin
        host_ad_out = 16'h0000;
        host_ale_out = 1'b0;
    end
    always @(posedge clk_sys_in) begin
        host_ale_out <= go_in;
        host_ad_out <= go_in ? addr_in : ~addr_in;
    end
    // Wire level: driver where enabled, peripherals elsewhere
    assign pin_level_out = (pin_drive_in & ~pin_oe_n_in) |
                           (EXT_LEVEL & pin_oe_n_in);
endmodule : ppla_host_model

// ===== bench/tb_port_pin_logic_and_address_out.sv
/*
 * Self-checking bench for the port pin block with its far-side model.
 * Assumes the register port answers one cycle after a read strobe.
 */
`timescale 1ns/1ps

module tb_port_pin_logic_and_address_out;
    import ppla_pkg::*;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [15:0] host_ad, host_addr = 16'h0000;
    logic host_ale, go = 1'b0;
    logic [31:0] pins, drive, oe_n;
    logic [31:0] la_sel = 32'h0100_0000;
    logic [31:0] la_data = 32'h0100_0000;
    logic [31:0] la_oe = 32'h0100_0000;
    logic [7:0] hi_sel = 8'h0f;
    logic cap_en = 1'b1;
    logic [23:0] imc_bus;
    logic [7:0] direct_bus;
    int fails = 0;
    int check_count = 0;

    // ======================================================
    // Clock and instances
    always #20 clk_sys_in = ~clk_sys_in;
    ppla_port_pins dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .host_ad_in(host_ad),
        .host_ale_in(host_ale), .pin_level_in(pins),
        .pin_drive_out(drive), .pin_oe_n_out(oe_n),
        .cfg_la_out_sel_in(la_sel), .cfg_hi_byte_sel_in(hi_sel),
        .la_data_in(la_data), .la_oe_in(la_oe),
        .imc_capture_en_in(cap_en), .imc_bus_out(imc_bus),
        .direct_bus_out(direct_bus));
    ppla_host_model host (.clk_sys_in(clk_sys_in), .go_in(go),
        .addr_in(host_addr), .pin_drive_in(drive), .pin_oe_n_in(oe_n),
        .host_ad_out(host_ad), .host_ale_out(host_ale),
        .pin_level_out(pins));

    // ======================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1;
        chk({24'h0, rdata}, {24'h0, exp});
    endtask : rreg
    task automatic settle;
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask : settle

    // ======================================================
    // Scenarios
    task automatic t_reset;
        #1;
        chk(oe_n, 32'hfeff_ffff);
        chk(drive, 32'h0100_0000);
        for (int p = 0; p < 4; p++) rreg(PPLA_DIR_OFS[p], 8'h00);
        rreg(8'h02, 8'h00);
        rreg(8'h03, 8'h00);
        rreg(8'h3f, 8'h00);
    endtask : t_reset
    task automatic t_fw_io;
        wreg(8'h04, 8'h5a);
        wreg(8'h06, 8'hff);
        settle();
        chk({oe_n[7:0], drive[7:0]}, 16'h005a);
        rreg(8'h00, 8'h5a);
    endtask : t_fw_io
    task automatic t_array;
        @(posedge clk_sys_in);
        la_sel <= 32'h01ff_0000;
        la_data <= 32'h013c_0000;
        la_oe <= 32'h010f_0100;
        wreg(8'h12, 8'hff);
        wreg(8'h14, 8'hff);
        settle();
        chk({oe_n[23:16], drive[23:16]}, 16'hf03c);
        chk({31'h0, oe_n[8]}, 32'h0);
        rreg(8'h1c, 8'h0f);
    endtask : t_array
    task automatic t_addr;
        @(posedge clk_sys_in);
        host_addr <= 16'h1234;
        go <= 1'b1;
        @(posedge clk_sys_in);
        go <= 1'b0;
        wreg(8'h02, 8'h0f);
        wreg(8'h03, 8'hff);
        settle();
        chk({oe_n[7:0], drive[7:0]}, 16'h0054);
        chk({oe_n[15:8], drive[15:8]}, 16'h0032);
        rreg(8'h02, 8'h0f);
    endtask : t_addr
    task automatic t_inputs;
        settle();
        chk({8'h0, imc_bus}, 32'h006c_3254);
        chk({24'h0, direct_bus}, 32'h97);
        rreg(8'h11, 8'h97);
    endtask : t_inputs

    // ======================================================
    // Closing and main sequence
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        @(posedge clk_sys_in);
        t_reset();
        t_fw_io();
        t_array();
        t_addr();
        t_inputs();
        report_and_stop();
    end
endmodule : tb_port_pin_logic_and_address_out

// ===== hdl/ppla_pkg.sv
/*
 * Constants for the port pin block: geometry, register offsets and
 * reset values. Assumes an 8-bit register port and four 8-pin ports.
 */
package ppla_pkg;

    // ==========================================================
    // Geometry
    localparam int PPLA_PIN_W = 8;       // Pins per port
    localparam int PPLA_NPORTS = 4;      // First to fourth port
    localparam int PPLA_IMC_PORTS = 3;   // Ports passed through input cells
    localparam int PPLA_ADDR_PORTS = 2;  // Ports able to drive address
    localparam int PPLA_PORT_A = 0;      // First port index
    localparam int PPLA_PORT_D = 3;      // Fourth port index
    localparam int PPLA_ADDR_W = 16;     // Host address width

    // ==========================================================
    // Register offsets, indexed by port
    localparam logic [7:0] PPLA_DIN_OFS [PPLA_NPORTS] =
        '{8'h00, 8'h01, 8'h10, 8'h11};
    localparam logic [7:0] PPLA_DOUT_OFS [PPLA_NPORTS] =
        '{8'h04, 8'h05, 8'h12, 8'h13};
    localparam logic [7:0] PPLA_DIR_OFS [PPLA_NPORTS] =
        '{8'h06, 8'h07, 8'h14, 8'h15};
    localparam logic [7:0] PPLA_OEN_OFS [PPLA_NPORTS] =
        '{8'h0c, 8'h0d, 8'h1c, 8'h1d};
    localparam logic [7:0] PPLA_CTRL_OFS [PPLA_ADDR_PORTS] =
        '{8'h02, 8'h03};

    // ==========================================================
    // Reset values
    localparam logic [PPLA_PIN_W-1:0] PPLA_RST_BYTE = 8'h00;
    localparam logic [PPLA_ADDR_W-1:0] PPLA_RST_ADDR = 16'h0000;

endpackage : ppla_pkg

// ===== hdl/ppla_port_pins.sv
/*
 * Port pin output control: firmware I/O registers, logic array pin
 * functions, input cells and latched address output for four ports.
 * Assumes pin levels, array terms and host bus are synchronous to
 * clk_sys_in, and pin function selects are static configuration.
 */
// Overview of operation
// - Pins of ports one to three reach the array through input cells.
// - Fourth port pins feed the array input bus directly.
// - Array outputs can drive pins on all four ports, port four included.
// - A pin assigned as array output ignores firmware I/O and other modes.
// - Data-in reads return pin level even for array input pins.
// - Direction bit still acts on an array input pin.
// - Firmware data-out does not reach a pin driven by the array.
// - Output enable is array enable term OR direction bit OR address control bit.
// - Direction registers reset to zero, pins high impedance unless their array enable term is true.
// - Array enable term true at power-on makes the pin an output.
// - An output cell used internally leaves its pin free.
// - Host address is captured with the address-latch strobe.
// - Address drive is selected pin by pin.
// - Low byte on ports one and two, high byte on port two only.
// - Port two low or high byte choice is fixed configuration.
// - Direction one means output, zero means input.
// - Control bit one drives address, zero keeps firmware I/O; resets 0.
`timescale 1ns/1ps

module ppla_port_pins
    import ppla_pkg::*;
#(
    parameter int PIN_W = PPLA_PIN_W
)
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [PIN_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [PIN_W-1:0] reg_rdata_out,
    input wire logic [2*PIN_W-1:0] host_ad_in,
    input wire logic host_ale_in,
    input wire logic [PPLA_NPORTS*PIN_W-1:0] pin_level_in,
    output logic [PPLA_NPORTS*PIN_W-1:0] pin_drive_out,
    output logic [PPLA_NPORTS*PIN_W-1:0] pin_oe_n_out,
    input wire logic [PPLA_NPORTS*PIN_W-1:0] cfg_la_out_sel_in,
    input wire logic [PIN_W-1:0] cfg_hi_byte_sel_in,
    input wire logic [PPLA_NPORTS*PIN_W-1:0] la_data_in,
    input wire logic [PPLA_NPORTS*PIN_W-1:0] la_oe_in,
    input wire logic imc_capture_en_in,
    output logic [PPLA_IMC_PORTS*PIN_W-1:0] imc_bus_out,
    output logic [PIN_W-1:0] direct_bus_out
);

    localparam int NPIN = PPLA_NPORTS * PIN_W;

    logic [PIN_W-1:0] dout_reg [PPLA_NPORTS];
    logic [PIN_W-1:0] dir_reg [PPLA_NPORTS];
    logic [PIN_W-1:0] ctrl_reg [PPLA_ADDR_PORTS];
    logic [2*PIN_W-1:0] addr_latch_reg;
    logic [NPIN-1:0] oe_reg;
    logic [NPIN-1:0] oe_next;
    logic [NPIN-1:0] drive_next;
    logic [NPIN-1:0] addr_en;
    logic [NPIN-1:0] addr_bit;
    logic [PIN_W-1:0] rdata_next;

    // ==========================================================
    // Register writes
    // Firmware data-out, direction and address control registers
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int p = 0; p < PPLA_NPORTS; p++) begin
                dout_reg[p] <= PPLA_RST_BYTE;
                dir_reg[p] <= PPLA_RST_BYTE;
            end
            for (int p = 0; p < PPLA_ADDR_PORTS; p++) begin
                ctrl_reg[p] <= PPLA_RST_BYTE;
            end
        end else if (reg_wr_in) begin
            for (int p = 0; p < PPLA_NPORTS; p++) begin
                if (reg_addr_in == PPLA_DOUT_OFS[p]) begin
                    dout_reg[p] <= reg_wdata_in;
                end
                if (reg_addr_in == PPLA_DIR_OFS[p]) begin
                    dir_reg[p] <= reg_wdata_in;
                end
            end
            for (int p = 0; p < PPLA_ADDR_PORTS; p++) begin
                if (reg_addr_in == PPLA_CTRL_OFS[p]) begin
                    ctrl_reg[p] <= reg_wdata_in;
                end
            end
        end
    end

    // ==========================================================
    // Register reads
    // Read mux; unmapped offsets read as zero
    always_comb begin
        rdata_next = '0;
        for (int p = 0; p < PPLA_NPORTS; p++) begin
            if (reg_addr_in == PPLA_DIN_OFS[p]) begin
                rdata_next = pin_level_in[p*PIN_W +: PIN_W];
            end
            if (reg_addr_in == PPLA_DOUT_OFS[p]) begin
                rdata_next = dout_reg[p];
            end
            if (reg_addr_in == PPLA_DIR_OFS[p]) begin
                rdata_next = dir_reg[p];
            end
            if (reg_addr_in == PPLA_OEN_OFS[p]) begin
                rdata_next = oe_reg[p*PIN_W +: PIN_W];
            end
        end
        for (int p = 0; p < PPLA_ADDR_PORTS; p++) begin
            if (reg_addr_in == PPLA_CTRL_OFS[p]) begin
                rdata_next = ctrl_reg[p];
            end
        end
    end

    // Read data stands for the one cycle after the strobe only
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rdata_next : '0;
        end
    end

    // ==========================================================
    // Address latch
    // Shared address/data lines captured while the strobe is high
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr_latch_reg <= PPLA_RST_ADDR;
        end else if (host_ale_in) begin
            addr_latch_reg <= host_ad_in;
        end
    end

    // ==========================================================
    // Array input paths
    // Input cells register the first three ports
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            imc_bus_out <= '0;
        end else if (imc_capture_en_in) begin
            imc_bus_out <= pin_level_in[PPLA_IMC_PORTS*PIN_W-1:0];
        end
    end

    // Fourth port bypasses the input cells
    assign direct_bus_out = pin_level_in[PPLA_PORT_D*PIN_W +: PIN_W];

    // ==========================================================
    // Per-pin output selection
    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        localparam int P = g / PIN_W;
        localparam int B = g % PIN_W;
        if (P < PPLA_ADDR_PORTS) begin : g_addr
            // Address drive chosen pin by pin, never on array outputs
            assign addr_en[g] = ctrl_reg[P][B] & ~cfg_la_out_sel_in[g];
            if (P == PPLA_PORT_A) begin : g_low
                assign addr_bit[g] = addr_latch_reg[B];
            end else begin : g_sel
                // Byte choice is a static configuration input
                assign addr_bit[g] = cfg_hi_byte_sel_in[B] ?
                    addr_latch_reg[B+PIN_W] : addr_latch_reg[B];
            end
        end else begin : g_noaddr
            assign addr_en[g] = 1'b0;
            assign addr_bit[g] = 1'b0;
        end

        // Enable is array term OR direction OR address drive, firmware locked out on outputs
        assign oe_next[g] = la_oe_in[g] |
            (~cfg_la_out_sel_in[g] & (dir_reg[P][B] | addr_en[g]));

        // Data source: array output, then latched address, then firmware
        assign drive_next[g] = cfg_la_out_sel_in[g] ? la_data_in[g] :
            (addr_en[g] ? addr_bit[g] : dout_reg[P][B]);

        AST_ARRAY_OE: assert property (@(posedge clk_sys_in)
            disable iff (!nrst_in)
            la_oe_in[g] |=> !pin_oe_n_out[g])
            else $error("Array enable term did not drive pin");
        AST_DIR_OUT: assert property (@(posedge clk_sys_in)
            disable iff (!nrst_in)
            (dir_reg[P][B] && !cfg_la_out_sel_in[g]) |=> !pin_oe_n_out[g])
            else $error("Direction bit did not enable pin");
        AST_LA_LOCK: assert property (@(posedge clk_sys_in)
            disable iff (!nrst_in)
            (cfg_la_out_sel_in[g] && !la_oe_in[g]) |=> pin_oe_n_out[g])
            else $error("Firmware enabled an array output pin");
        AST_LA_DATA: assert property (@(posedge clk_sys_in)
            disable iff (!nrst_in)
            cfg_la_out_sel_in[g] |=> pin_drive_out[g] == $past(la_data_in[g]))
            else $error("Array output pin not driven by array");
        AST_ADDR_DATA: assert property (@(posedge clk_sys_in)
            disable iff (!nrst_in)
            addr_en[g] |=> pin_drive_out[g] == $past(addr_bit[g]))
            else $error("Address pin not driven by latched address");
        AST_FW_DATA: assert property (@(posedge clk_sys_in)
            disable iff (!nrst_in)
            (!cfg_la_out_sel_in[g] && !addr_en[g])
            |=> pin_drive_out[g] == $past(dout_reg[P][B]))
            else $error("Firmware data not on free pin");
    end

    // ==========================================================
    // Pin drivers
    // Registered pin data and active-low enables
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_drive_out <= '0;
            pin_oe_n_out <= '1;
            oe_reg <= '0;
        end else begin
            pin_drive_out <= drive_next;
            pin_oe_n_out <= ~oe_next;
            oe_reg <= oe_next;
        end
    end

    // ==========================================================
    // Checks on shared paths
    AST_ALE_CAPTURE: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        host_ale_in |=> addr_latch_reg == $past(host_ad_in))
        else $error("Address not captured on strobe");
    AST_ALE_HOLD: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        !host_ale_in |=> $stable(addr_latch_reg))
        else $error("Latched address moved without strobe");
    AST_DIN_READ: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        (reg_rd_in && reg_addr_in == PPLA_DIN_OFS[PPLA_PORT_A])
        |=> reg_rdata_out == $past(pin_level_in[PIN_W-1:0]))
        else $error("Data-in read lost pin level");
    AST_RDATA_IDLE: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        !reg_rd_in |=> reg_rdata_out == '0)
        else $error("Read data outside its cycle");
    AST_IMC_PATH: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        imc_capture_en_in
        |=> imc_bus_out == $past(pin_level_in[PPLA_IMC_PORTS*PIN_W-1:0]))
        else $error("Input cell missed pin level");
    AST_DIRECT_PATH: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        direct_bus_out == pin_level_in[PPLA_PORT_D*PIN_W +: PIN_W])
        else $error("Fourth port not passed directly");
    AST_DIR_RESET: assert property (@(posedge clk_sys_in)
        $rose(nrst_in) |-> (dir_reg[PPLA_PORT_A] == PPLA_RST_BYTE
            && pin_oe_n_out == '1))
        else $error("Pins not high impedance after reset");

    // ==========================================================
    // Checks on the register port
    // Control registers come out of reset cleared
    AST_CTRL_RESET: assert property (@(posedge clk_sys_in)
        $rose(nrst_in) |-> (ctrl_reg[0] == PPLA_RST_BYTE
            && ctrl_reg[1] == PPLA_RST_BYTE))
        else $error("Address control not cleared by reset");

    // A direction write lands in the next cycle
    AST_DIR_WRITE: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        (reg_wr_in && reg_addr_in == PPLA_DIR_OFS[PPLA_PORT_A])
        |=> dir_reg[PPLA_PORT_A] == $past(reg_wdata_in))
        else $error("Direction write lost");

    // A control write lands in the next cycle
    AST_CTRL_WRITE: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        (reg_wr_in && reg_addr_in == PPLA_CTRL_OFS[PPLA_PORT_A])
        |=> ctrl_reg[PPLA_PORT_A] == $past(reg_wdata_in))
        else $error("Address control write lost");

    // Direction readback returns the stored byte
    AST_DIR_READ: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        (reg_rd_in && reg_addr_in == PPLA_DIR_OFS[PPLA_PORT_A])
        |=> reg_rdata_out == $past(dir_reg[PPLA_PORT_A]))
        else $error("Direction readback wrong");

    // Control readback returns the stored byte
    AST_CTRL_READ: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        (reg_rd_in && reg_addr_in == PPLA_CTRL_OFS[PPLA_PORT_A])
        |=> reg_rdata_out == $past(ctrl_reg[PPLA_PORT_A]))
        else $error("Address control readback wrong");

    // Enable readback shows the final driver enable
    AST_OE_READ: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        (reg_rd_in && reg_addr_in == PPLA_OEN_OFS[PPLA_PORT_A])
        |=> reg_rdata_out == ~$past(pin_oe_n_out[PIN_W-1:0]))
        else $error("Enable readback differs from pin enable");

    // Data-out readback returns the stored byte
    AST_DOUT_READ: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        (reg_rd_in && reg_addr_in == PPLA_DOUT_OFS[PPLA_PORT_A])
        |=> reg_rdata_out == $past(dout_reg[PPLA_PORT_A]))
        else $error("Data-out readback wrong");

    // Ports without address drive never select it
    AST_NO_ADDR_HIGH: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        addr_en[NPIN-1:PPLA_ADDR_PORTS*PIN_W] == '0)
        else $error("Address drive on a port without it");

endmodule : ppla_port_pins
